// file: src/tfm_modem.sv
// tape fsk modem: interval timer, tape port lines and bit sequencers
//
// Notes on behaviour
// - one is 2 kHz period, zero 1 kHz
// - only port bit 1 drives, others input
// - prescaler advanced by 4 MHz system tick
// - preload half bit period before each bit
// - drive line high, start counter, await flag
// - on expiry stop, drive low, restart, await
// - restart reloads counter from stored preload
// - receive by timing rising edge to edge
// - wait for first rising edge before measuring
// - start on high, stop after low-high, capture
// - period is preload minus captured count
// - counter is 24-bit synchronous down counter
// - preload built from three 8-bit registers
// - counter via divide-by-32 prescaler or direct
// - count clock is system tick or pin
// - reload, rollover, square wave, one-shot modes
// - zero reached sets the single status flag
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tfm_modem #(
  parameter int CLK_HZ = tfm_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // register port
  input  wire tfm_pkg::tfm_bus_req_type bus_req,
  output logic [7:0]                    bus_rdata,
  // tape and timer pins
  output logic                          tape_tx_line,
  output logic                          tape_tx_oe,
  input  wire logic                     tape_rx_line,
  input  wire logic                     external_count_clock_in,
  output logic                          timer_wave_out
);
  localparam int TICK_DIV = CLK_HZ / tfm_pkg::SYS_HZ;
  localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

  if (CLK_HZ % tfm_pkg::SYS_HZ != 0 || TICK_DIV < 2 || TICK_DIV > 16) begin : g_bad_clk
    $error("clock must be 2..16 times the system tick");
  end

  typedef struct packed {
    logic [3:0]          tick_div;
    logic [4:0]          presc;
    logic [23:0]         ctr;
    logic [23:0]         pre;
    logic                en;
    logic                psc_use;
    logic                ext;
    tfm_pkg::tfm_mode_type mode;
    logic                zflag;
    logic                wave;
    logic                dir_tx;
    logic                tx;
    tfm_pkg::tfm_tx_type txst;
    tfm_pkg::tfm_rx_type rxst;
    logic                rx_bit;
    logic                rx_valid;
    logic [23:0]         period;
    logic [7:0]          rdata;
    logic [2:0]          rx_sync;
    logic                rx_lvl;
    logic                rx_prev;
    logic [2:0]          ext_sync;
    logic                ext_lvl;
    logic                ext_prev;
  } tfm_state_type;

  tfm_state_type st_reg;
  tfm_state_type st_next;
  logic          sys_tick;
  logic          src_tick;
  logic          cnt_tick;
  logic          zero_evt;
  logic          rx_rise;
  logic          wr_hit;
  logic          rd_hit;
  logic          zclr;
  logic          vclr;

  always_comb begin
    st_next = st_reg;
    wr_hit  = bus_req.wr;
    rd_hit  = bus_req.rd;
    zclr    = 1'b0;
    vclr    = 1'b0;
    // pin synchronisers, level taken once stages two and three agree
    st_next.rx_sync  = {st_reg.rx_sync[1:0], tape_rx_line};
    st_next.ext_sync = {st_reg.ext_sync[1:0], external_count_clock_in};
    if (st_reg.rx_sync[1] == st_reg.rx_sync[2]) begin
      st_next.rx_lvl = st_reg.rx_sync[2];
    end
    if (st_reg.ext_sync[1] == st_reg.ext_sync[2]) begin
      st_next.ext_lvl = st_reg.ext_sync[2];
    end
    st_next.rx_prev  = st_reg.rx_lvl;
    st_next.ext_prev = st_reg.ext_lvl;
    rx_rise = st_reg.rx_lvl & ~st_reg.rx_prev;
    // system tick stands in for the falling edge of the slow system clock
    sys_tick = (st_reg.tick_div == TICK_LAST);
    st_next.tick_div = sys_tick ? 4'h0 : st_reg.tick_div + 4'h1;
    src_tick = st_reg.ext ? (st_reg.ext_lvl & ~st_reg.ext_prev) : sys_tick;
    if (src_tick) begin
      st_next.presc = st_reg.presc + 5'h01;
    end
    cnt_tick = src_tick & (~st_reg.psc_use | (st_reg.presc == 5'h1F));
    zero_evt = st_reg.en & cnt_tick & (st_reg.ctr == 24'h000001);
    // counter proper
    if (st_reg.en && cnt_tick) begin
      if (st_reg.ctr != 24'h000000) begin
        st_next.ctr = st_reg.ctr - 24'h000001;
        if (zero_evt && st_reg.mode == tfm_pkg::TFM_SQUARE) begin
          st_next.wave = ~st_reg.wave;
        end
      end else begin
        unique case (st_reg.mode)
          tfm_pkg::TFM_RELOAD,
          tfm_pkg::TFM_SQUARE:   st_next.ctr = st_reg.pre;
          tfm_pkg::TFM_ROLLOVER: st_next.ctr = 24'hFFFFFF;
          tfm_pkg::TFM_ONESHOT:  st_next.en = 1'b0;
        endcase
      end
    end
    // register writes
    if (wr_hit) begin
      unique case (bus_req.addr)
        tfm_pkg::REG_CTRL: begin
          if (bus_req.wdata[tfm_pkg::CTRL_EN] && !st_reg.en) begin
            st_next.ctr   = st_reg.pre;
            st_next.presc = 5'h00;
          end
          st_next.en      = bus_req.wdata[tfm_pkg::CTRL_EN];
          st_next.psc_use = bus_req.wdata[tfm_pkg::CTRL_PSC];
          st_next.ext     = bus_req.wdata[tfm_pkg::CTRL_EXT];
          st_next.mode    = tfm_pkg::tfm_mode_type'(bus_req.wdata[tfm_pkg::CTRL_MODE +: 2]);
        end
        tfm_pkg::REG_STATUS: begin
          zclr = bus_req.wdata[tfm_pkg::ST_ZERO];
          vclr = bus_req.wdata[tfm_pkg::ST_RXVALID];
        end
        tfm_pkg::REG_PRE_HI: st_next.pre[23:16] = bus_req.wdata;
        tfm_pkg::REG_PRE_MD: st_next.pre[15:8]  = bus_req.wdata;
        tfm_pkg::REG_PRE_LO: st_next.pre[7:0]   = bus_req.wdata;
        tfm_pkg::REG_DIR:    st_next.dir_tx = bus_req.wdata[tfm_pkg::DIR_TX];
        tfm_pkg::REG_PORT: begin
          if (st_reg.txst == tfm_pkg::TFM_TX_IDLE) begin
            st_next.tx = bus_req.wdata[tfm_pkg::DIR_TX];
          end
        end
        tfm_pkg::REG_RXCTL: begin
          st_next.rxst = bus_req.wdata[0] ? tfm_pkg::TFM_RX_RISE : tfm_pkg::TFM_RX_OFF;
        end
        default: ;
      endcase
    end
    // transmit sequencer; a transmit request overrides the timer setup
    unique case (st_reg.txst)
      tfm_pkg::TFM_TX_IDLE: begin
        if (wr_hit && bus_req.addr == tfm_pkg::REG_TXBIT) begin
          st_next.pre     = bus_req.wdata[0] ? tfm_pkg::ONE_HALF_CNT : tfm_pkg::ZERO_HALF_CNT;
          st_next.ctr     = st_next.pre;
          st_next.presc   = 5'h00;
          st_next.en      = 1'b1;
          st_next.psc_use = 1'b1;
          st_next.ext     = 1'b0;
          st_next.mode    = tfm_pkg::TFM_RELOAD;
          st_next.tx      = 1'b1;
          st_next.rxst    = tfm_pkg::TFM_RX_OFF;
          st_next.txst    = tfm_pkg::TFM_TX_HIGH;
        end
      end
      tfm_pkg::TFM_TX_HIGH: begin
        if (zero_evt) begin
          st_next.tx    = 1'b0;
          st_next.ctr   = st_reg.pre;
          st_next.presc = 5'h00;
          st_next.txst  = tfm_pkg::TFM_TX_LOW;
        end
      end
      tfm_pkg::TFM_TX_LOW: begin
        if (zero_evt) begin
          st_next.en   = 1'b0;
          st_next.ctr  = 24'h000000;
          st_next.txst = tfm_pkg::TFM_TX_IDLE;
        end
      end
      default: st_next.txst = tfm_pkg::TFM_TX_IDLE;
    endcase
    // receive sequencer, needs a non-inverted wave on the line
    if (st_reg.txst == tfm_pkg::TFM_TX_IDLE) begin
      unique case (st_reg.rxst)
        tfm_pkg::TFM_RX_OFF: ;
        tfm_pkg::TFM_RX_RISE: begin
          if (rx_rise) begin
            st_next.pre     = tfm_pkg::RX_PRELOAD;
            st_next.ctr     = tfm_pkg::RX_PRELOAD;
            st_next.presc   = 5'h00;
            st_next.en      = 1'b1;
            st_next.psc_use = 1'b1;
            st_next.ext     = 1'b0;
            st_next.mode    = tfm_pkg::TFM_RELOAD;
            st_next.rxst    = tfm_pkg::TFM_RX_LOW;
          end
        end
        tfm_pkg::TFM_RX_LOW: begin
          if (!st_reg.rx_lvl) begin
            st_next.rxst = tfm_pkg::TFM_RX_HIGH;
          end
        end
        tfm_pkg::TFM_RX_HIGH: begin
          if (rx_rise) begin
            st_next.period   = st_reg.pre - st_reg.ctr;
            st_next.rx_bit   = (st_reg.pre - st_reg.ctr) < tfm_pkg::ONE_LIMIT_CNT;
            st_next.ctr      = st_reg.pre;
            st_next.presc    = 5'h00;
            st_next.rxst     = tfm_pkg::TFM_RX_LOW;
          end
        end
        default: st_next.rxst = tfm_pkg::TFM_RX_OFF;
      endcase
    end
    // sticky flags, a set in the clearing cycle wins
    st_next.zflag    = (st_reg.zflag & ~zclr) | zero_evt;
    st_next.rx_valid = (st_reg.rx_valid & ~vclr)
                     | (st_reg.txst == tfm_pkg::TFM_TX_IDLE && st_reg.rxst == tfm_pkg::TFM_RX_HIGH && rx_rise);
    // read data stands only in the cycle after the strobe
    st_next.rdata = 8'h00;
    if (rd_hit) begin
      unique case (bus_req.addr)
        tfm_pkg::REG_CTRL:   st_next.rdata = {3'h0, st_reg.mode, st_reg.ext, st_reg.psc_use, st_reg.en};
        tfm_pkg::REG_STATUS: st_next.rdata = {3'h0, st_reg.rxst != tfm_pkg::TFM_RX_OFF
                                              && st_reg.rxst != tfm_pkg::TFM_RX_RISE,
                                              st_reg.rx_bit, st_reg.rx_valid,
                                              st_reg.txst != tfm_pkg::TFM_TX_IDLE, st_reg.zflag};
        tfm_pkg::REG_PRE_HI: st_next.rdata = st_reg.pre[23:16];
        tfm_pkg::REG_PRE_MD: st_next.rdata = st_reg.pre[15:8];
        tfm_pkg::REG_PRE_LO: st_next.rdata = st_reg.pre[7:0];
        tfm_pkg::REG_CNT_HI: st_next.rdata = st_reg.ctr[23:16];
        tfm_pkg::REG_CNT_MD: st_next.rdata = st_reg.ctr[15:8];
        tfm_pkg::REG_CNT_LO: st_next.rdata = st_reg.ctr[7:0];
        tfm_pkg::REG_DIR:    st_next.rdata = {6'h00, st_reg.dir_tx, 1'b0};
        tfm_pkg::REG_PORT:   st_next.rdata = {6'h00, st_reg.tx, st_reg.rx_lvl};
        tfm_pkg::REG_PER_HI: st_next.rdata = st_reg.period[23:16];
        tfm_pkg::REG_PER_MD: st_next.rdata = st_reg.period[15:8];
        tfm_pkg::REG_PER_LO: st_next.rdata = st_reg.period[7:0];
        default:             st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg        <= '0;
      st_reg.dir_tx <= tfm_pkg::DIR_RESET[tfm_pkg::DIR_TX];
      st_reg.mode   <= tfm_pkg::tfm_mode_type'(tfm_pkg::MODE_RESET);
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata      = st_reg.rdata;
  assign tape_tx_line   = st_reg.tx;
  assign tape_tx_oe     = st_reg.dir_tx;
  assign timer_wave_out = st_reg.wave;

  a_sys_tick_gap: assert property (@(posedge clk) disable iff (!resetn)
    sys_tick |=> !sys_tick [*4]) else $error("system tick spacing wrong");
  a_tx_bit_start: assert property (@(posedge clk) disable iff (!resetn)
    (st_reg.txst == tfm_pkg::TFM_TX_IDLE && bus_req.wr && bus_req.addr == tfm_pkg::REG_TXBIT)
    |=> tape_tx_line && st_reg.en
        && st_reg.ctr == ($past(bus_req.wdata[0]) ? tfm_pkg::ONE_HALF_CNT : tfm_pkg::ZERO_HALF_CNT))
    else $error("transmit bit did not start");
  a_tx_half_swap: assert property (@(posedge clk) disable iff (!resetn)
    (st_reg.txst == tfm_pkg::TFM_TX_HIGH && zero_evt)
    |=> !tape_tx_line && st_reg.ctr == st_reg.pre && st_reg.txst == tfm_pkg::TFM_TX_LOW)
    else $error("second half did not start");
  a_zero_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    zero_evt |=> st_reg.zflag && st_reg.ctr != 24'h000001) else $error("zero flag missed");
  a_ctr_down_one: assert property (@(posedge clk) disable iff (!resetn)
    (st_reg.en && cnt_tick && st_reg.ctr > 24'h000001 && st_reg.txst == tfm_pkg::TFM_TX_IDLE
     && !bus_req.wr && st_reg.rxst != tfm_pkg::TFM_RX_HIGH)
    |=> st_reg.ctr == $past(st_reg.ctr) - 24'h000001) else $error("counter did not decrement");
  a_presc_wrap: assert property (@(posedge clk) disable iff (!resetn)
    (cnt_tick && st_reg.psc_use) |=> st_reg.presc == 5'h00) else $error("prescaler not 32");
  a_rx_period: assert property (@(posedge clk) disable iff (!resetn)
    (st_reg.txst == tfm_pkg::TFM_TX_IDLE && st_reg.rxst == tfm_pkg::TFM_RX_HIGH && rx_rise)
    |=> st_reg.period == $past(st_reg.pre) - $past(st_reg.ctr) && st_reg.rx_valid
        && st_reg.rx_bit == (st_reg.period < tfm_pkg::ONE_LIMIT_CNT))
    else $error("receive period wrong");
  a_rx_wait_sync: assert property (@(posedge clk) disable iff (!resetn)
    (st_reg.rxst == tfm_pkg::TFM_RX_RISE && !rx_rise && !bus_req.wr)
    |=> st_reg.rxst == tfm_pkg::TFM_RX_RISE) else $error("receiver left sync wait early");
  a_tx_oe_only: assert property (@(posedge clk) disable iff (!resetn)
    (bus_req.wr && bus_req.addr == tfm_pkg::REG_DIR)
    |=> tape_tx_oe == $past(bus_req.wdata[tfm_pkg::DIR_TX])) else $error("direction bit wrong");
endmodule
`default_nettype wire

// file: src/tfm_pkg.sv
// package: register map, field layout and timing constants of the tape modem
package tfm_pkg;
  // clock figures
  localparam int CLK_HZ     = 20_000_000;
  localparam int SYS_HZ     = 4_000_000;
  localparam int PRESC_DIV  = 32;
  localparam int TICK_NS    = (1_000_000_000 / SYS_HZ) * PRESC_DIV;
  // bit timing, microseconds as printed
  localparam int ZERO_HALF_US = 500;
  localparam int ONE_HALF_US  = 250;
  localparam int ONE_LIMIT_US = 750;
  localparam logic [23:0] ZERO_HALF_CNT = 24'(ZERO_HALF_US * 1000 / TICK_NS);
  localparam logic [23:0] ONE_HALF_CNT  = 24'(ONE_HALF_US * 1000 / TICK_NS);
  localparam logic [23:0] ONE_LIMIT_CNT = 24'(ONE_LIMIT_US * 1000 / TICK_NS);
  localparam logic [23:0] RX_PRELOAD    = 24'hFFFFFF;
  // register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PRE_HI = 4'h2;
  localparam logic [3:0] REG_PRE_MD = 4'h3;
  localparam logic [3:0] REG_PRE_LO = 4'h4;
  localparam logic [3:0] REG_CNT_HI = 4'h5;
  localparam logic [3:0] REG_CNT_MD = 4'h6;
  localparam logic [3:0] REG_CNT_LO = 4'h7;
  localparam logic [3:0] REG_DIR    = 4'h8;
  localparam logic [3:0] REG_PORT   = 4'h9;
  localparam logic [3:0] REG_TXBIT  = 4'hA;
  localparam logic [3:0] REG_RXCTL  = 4'hB;
  localparam logic [3:0] REG_PER_HI = 4'hC;
  localparam logic [3:0] REG_PER_MD = 4'hD;
  localparam logic [3:0] REG_PER_LO = 4'hE;
  // field positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_PSC   = 1;
  localparam int CTRL_EXT   = 2;
  localparam int CTRL_MODE  = 3;
  localparam int ST_ZERO    = 0;
  localparam int ST_TXBUSY  = 1;
  localparam int ST_RXVALID = 2;
  localparam int ST_RXBIT   = 3;
  localparam int ST_RXSYNC  = 4;
  localparam int DIR_TX     = 1;
  localparam int PORT_RX    = 0;
  // reset values
  localparam logic [7:0] DIR_RESET  = 8'h02;
  localparam logic [1:0] MODE_RESET = 2'h0;
  typedef enum logic [1:0] {
    TFM_RELOAD, TFM_ROLLOVER, TFM_SQUARE, TFM_ONESHOT
  } tfm_mode_type;
  typedef enum logic [1:0] {TFM_TX_IDLE, TFM_TX_HIGH, TFM_TX_LOW} tfm_tx_type;
  typedef enum logic [1:0] {
    TFM_RX_OFF, TFM_RX_RISE, TFM_RX_LOW, TFM_RX_HIGH
  } tfm_rx_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tfm_bus_req_type;
endpackage

// file: test/tfm_modem_tb.sv
// self-checking bench for the tape fsk modem
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp); end end
module tfm_modem_tb;
  logic                     clk;
  logic                     resetn;
  tfm_pkg::tfm_bus_req_type bus_req;
  logic [7:0]               bus_rdata;
  logic                     tape_tx_line;
  logic                     tape_tx_oe;
  logic                     tape_rx_line;
  logic                     ext_clk;
  logic                     timer_wave_out;
  int                       errors;
  int                       n_compared;
  int                       hi_n;
  int                       lo_n;
  logic [7:0]               d;
  logic [23:0]              v;
  logic                     w0;
  logic [23:0]              exp_mode [4];

  tfm_modem u_dut (
    .clk                     (clk),
    .resetn                  (resetn),
    .bus_req                 (bus_req),
    .bus_rdata               (bus_rdata),
    .tape_tx_line            (tape_tx_line),
    .tape_tx_oe              (tape_tx_oe),
    .tape_rx_line            (tape_rx_line),
    .external_count_clock_in (ext_clk),
    .timer_wave_out          (timer_wave_out)
  );
  tfm_tape_deck u_deck (
    .rx_level (tape_rx_line)
  );

  always #25 clk = ~clk;

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    x = bus_rdata;
  endtask

  // no latching: count must be frozen while the three bytes are read
  task automatic rd24(input logic [3:0] a, output logic [23:0] x);
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
    rd(a, b2);
    rd(a + 4'h1, b1);
    rd(a + 4'h2, b0);
    x = {b2, b1, b0};
  endtask

  // wide pulses so the 3-flop synchroniser sees each one
  task automatic ext_tick();
    @(posedge clk);
    ext_clk <= 1'b1;
    repeat (4) @(posedge clk);
    ext_clk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic tx_bit(input logic b, input logic [23:0] half);
    hi_n = 0;
    lo_n = 0;
    wr(tfm_pkg::REG_STATUS, 8'h01);
    wr(tfm_pkg::REG_TXBIT, {7'h00, b});
    @(negedge clk);
    `CHK(tape_tx_line, 1'b1)
    while (tape_tx_line === 1'b1 && hi_n < 20000) begin
      @(negedge clk);
      hi_n++;
    end
    rd(tfm_pkg::REG_STATUS, d);
    `CHK(d[1:0], 2'b11)
    rd(tfm_pkg::REG_CNT_LO, d);
    `CHK(d == half[7:0] || d == half[7:0] - 8'h01, 1'b1)
    wr(tfm_pkg::REG_STATUS, 8'h01);
    d = 8'h02;
    while (d[1] !== 1'b0 && lo_n < 20000) begin
      rd(tfm_pkg::REG_STATUS, d);
      lo_n += 2;
    end
    `CHK(d[0], 1'b1)
    `CHK(hi_n >= int'(half) * 160 - 8 && hi_n <= int'(half) * 160 + 168, 1'b1)
    `CHK(lo_n >= int'(half) * 160 - 40 && lo_n <= int'(half) * 160 + 168, 1'b1)
    rd(tfm_pkg::REG_PRE_LO, d);
    `CHK(d, half[7:0])
  endtask

  initial begin
    #5_000_000;
    errors++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    bus_req = '0;
    ext_clk = 1'b0;
    errors = 0;
    n_compared = 0;
    exp_mode = '{24'h000002, 24'hFFFFFF, 24'h000002, 24'h000000};
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK(tape_tx_oe, 1'b1)
    rd(tfm_pkg::REG_DIR, d);
    `CHK(d, tfm_pkg::DIR_RESET)
    @(negedge clk);
    `CHK(bus_rdata, 8'h00)
    wr(tfm_pkg::REG_DIR, 8'hFD);
    @(negedge clk);
    `CHK(tape_tx_oe, 1'b0)
    rd(tfm_pkg::REG_DIR, d);
    `CHK(d, 8'h00)
    wr(tfm_pkg::REG_DIR, 8'hFF);
    rd(tfm_pkg::REG_DIR, d);
    `CHK(d, tfm_pkg::DIR_RESET)
    wr(tfm_pkg::REG_PORT, 8'h02);
    rd(tfm_pkg::REG_PORT, d);
    `CHK(d, 8'h02)
    `CHK(tape_tx_line, 1'b1)
    wr(tfm_pkg::REG_PORT, 8'h00);
    rd(4'hF, d);
    `CHK(d, 8'h00)
    wr(tfm_pkg::REG_PRE_HI, 8'hA5);
    wr(tfm_pkg::REG_PRE_MD, 8'h5A);
    wr(tfm_pkg::REG_PRE_LO, 8'hC3);
    rd24(tfm_pkg::REG_PRE_HI, v);
    `CHK(v, 24'hA55AC3)
    // every counter mode, direct from the external pin
    for (int m = 0; m < 4; m++) begin
      wr(tfm_pkg::REG_PRE_HI, 8'h00);
      wr(tfm_pkg::REG_PRE_MD, 8'h00);
      wr(tfm_pkg::REG_PRE_LO, 8'h02);
      wr(tfm_pkg::REG_CTRL, 8'h00);
      wr(tfm_pkg::REG_STATUS, 8'h01);
      w0 = timer_wave_out;
      wr(tfm_pkg::REG_CTRL, 8'h05 | 8'(m << 3));
      ext_tick();
      ext_tick();
      rd(tfm_pkg::REG_STATUS, d);
      `CHK(d[0], 1'b1)
      ext_tick();
      rd24(tfm_pkg::REG_CNT_HI, v);
      `CHK(v, exp_mode[m])
      if (m == 2) begin
        `CHK(timer_wave_out, ~w0)
      end
      if (m == 3) begin
        rd(tfm_pkg::REG_CTRL, d);
        `CHK(d[0], 1'b0)
      end
    end
    wr(tfm_pkg::REG_CTRL, 8'h00);
    wr(tfm_pkg::REG_STATUS, 8'h01);
    tx_bit(1'b1, tfm_pkg::ONE_HALF_CNT);
    tx_bit(1'b0, tfm_pkg::ZERO_HALF_CNT);
    // receive: zero leader, one data bit, then a closing rise
    wr(tfm_pkg::REG_RXCTL, 8'h01);
    fork
      begin
        u_deck.play_leader(1);
        u_deck.play_bit(1'b1);
        u_deck.play_bit(1'b1);
      end
    join_none
    rd(tfm_pkg::REG_STATUS, d);
    `CHK(d[4], 1'b0)
    for (int k = 0; k < 2; k++) begin
      hi_n = 0;
      d = 8'h00;
      while (d[2] !== 1'b1 && hi_n < 20000) begin
        rd(tfm_pkg::REG_STATUS, d);
        hi_n++;
      end
      if (hi_n >= 20000) begin
        errors++;
        stop_test();
      end
      `CHK(d[3], k == 1)
      `CHK(d[4], 1'b1)
      rd24(tfm_pkg::REG_PER_HI, v);
      lo_n = int'(v) - 2 * int'(k == 1 ? tfm_pkg::ONE_HALF_CNT : tfm_pkg::ZERO_HALF_CNT);
      `CHK(lo_n >= -1 && lo_n <= 3, 1'b1)
      wr(tfm_pkg::REG_STATUS, 8'h04);
    end
    stop_test();
  end
endmodule
`default_nettype wire

// file: test/tfm_tape_deck.sv
// tape player model driving the conditioned receive line
`timescale 1ns/10ps
`default_nettype none
module tfm_tape_deck #(
  parameter int ONE_HALF_NS  = 250_000,
  parameter int ZERO_HALF_NS = 500_000
) (
  // conditioned playback signal, comparator always drives it
  output logic rx_level
);
  initial rx_level = 1'b0;
  // one bit: high half first so rises mark bit starts
  // nonblocking, so a change on a clock edge lands after the flops sample
  task automatic play_bit(input logic b);
    rx_level <= 1'b1;
    #(b ? ONE_HALF_NS : ZERO_HALF_NS);
    rx_level <= 1'b0;
    #(b ? ONE_HALF_NS : ZERO_HALF_NS);
  endtask
  // zero leader ahead of data; shortened to keep the run short
  task automatic play_leader(input int n);
    repeat (n) play_bit(1'b0);
  endtask
endmodule
`default_nettype wire
